// ---- design/bsfc_params.svh ----
/*
 Timing counts, register offsets, field positions and reset values for the host-side
 flash sequencer. Assumes a 100 MHz clock and classic Wishbone register access.
*/
`ifndef BSFC_PARAMS_SVH
`define BSFC_PARAMS_SVH
// Register offsets (byte addresses)
`define BSFC_REG_CTRL 4'h0
`define BSFC_REG_ADDR 4'h4
`define BSFC_REG_DATA 4'h8
`define BSFC_REG_STAT 4'hC
// Control fields
`define BSFC_CTRL_GO 0
`define BSFC_CTRL_CMD_LSB 4
`define BSFC_CTRL_CMD_MSB 7
`define BSFC_CTRL_BYPASS 8
`define BSFC_CTRL_HWRST 9
`define BSFC_CTRL_WPN 10
// Status fields
`define BSFC_STAT_BUSY 0
`define BSFC_STAT_DONE 1
`define BSFC_STAT_ERR 2
`define BSFC_STAT_RYBY 3
`define BSFC_STAT_BYPASS 4
// Reset values
`define BSFC_CTRL_RST 11'h400
// Timing: strobe (also used for the gap) and reset pulse widths in ns and the derived cycle counts
`define BSFC_STROBE_NS 100
`define BSFC_CLK_NS 10
`define BSFC_STROBE_CYC ((`BSFC_STROBE_NS + `BSFC_CLK_NS - 1) / `BSFC_CLK_NS)
`define BSFC_RST_NS 500
`define BSFC_RST_CYC ((`BSFC_RST_NS + `BSFC_CLK_NS - 1) / `BSFC_CLK_NS)
// Polling gives up after this many reads
`define BSFC_POLL_MAX 24'hFFFFFF
// Unlock addresses and data
`define BSFC_UNL_A1 21'h000555
`define BSFC_UNL_A2 21'h0002AA
`define BSFC_UNL_D1 16'h00AA
`define BSFC_UNL_D2 16'h0055
`endif

// ---- design/bsfc_pkg.sv ----
/*
 Types shared by the host-side flash sequencer.
 Assumes the params header supplies every number.
*/
package bsfc_pkg;
    // Host orders carried in the control register
    typedef enum logic [3:0] {
        BSFC_OP_READ,
        BSFC_OP_PROG,
        BSFC_OP_SECT_ERASE,
        BSFC_OP_SUSPEND,
        BSFC_OP_RESUME,
        BSFC_OP_RESET_CMD,
        BSFC_OP_REGION_ENTER,
        BSFC_OP_REGION_EXIT,
        BSFC_OP_BYPASS_ENTER,
        BSFC_OP_BYPASS_EXIT
    } bsfc_op_t;
    // One bus cycle on the flash pins
    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] data;
        logic write;
    } bsfc_cyc_t;
    // Flash pin bundle driven by the sequencer
    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic read_drive_n;
        logic reset_n;
        logic edge_sector_lock_n;
        logic [20:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
    } bsfc_pins_t;
endpackage

// ---- design/bsfc_ctrl.sv ----
/*
 Host-side controller for a boot-sector NOR flash: turns Wishbone orders into command
 write sequences on the asynchronous strobe bus and polls status until done.
 Assumes the flash pins (dq, ready_busy_n) are asynchronous to clk_i.
*/
// Operation
// R1: Address 2M words, sixteen-bit data bus
// R2: Sector address taken from host address
// R3: Page reads are plain single reads here
// R4: Buffer programming left to software sequences
// R5: Commands issued as ordinary write cycles
// R6: Start by sequence, poll toggle bit
// R7: Ready-busy pin sampled into status
// R8: Bypass mode uses two-cycle program
// R9: Erase targets only one sector
// R10: Refused operations flagged as error
// R11: Erase suspend and resume commands
// R12: Program suspend and resume commands
// R13: Hardware reset pulse on reset pin
// R14: Chip select released between cycles
// R15: Edge-sector lock pin from control
// R16: Secured region entered by sequence
// R17: Serial number read inside region
// R18: Three separate active-low strobes driven
// R19: No erase forced before programming
// R20: Reset command returns to array read
// R21: Programming only clears bits, not checked
`timescale 1ns/1ns
`include "bsfc_params.svh"
module bsfc_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output bsfc_pkg::bsfc_pins_t pins_o,
    input wire logic [15:0] dq_i,
    input wire logic ready_busy_n_i
);
    import bsfc_pkg::*;

    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_STROBE, S_GAP, S_POLL, S_HWRST
    } bsfc_state_t;

    // Software-visible registers
    logic [10:0] ctrl_q, ctrl_d;
    logic [20:0] addr_q, addr_d;
    logic [15:0] wdat_q, wdat_d;
    logic [15:0] rdat_q, rdat_d;
    logic done_q, done_d;
    logic err_q, err_d;
    logic bypass_q, bypass_d;
    // Sequencer state
    bsfc_state_t st_q, st_d;
    logic [2:0] idx_q, idx_d;     // Cycle index within a sequence
    logic [2:0] len_q, len_d;     // Cycles in the current sequence
    logic [7:0] tmr_q, tmr_d;     // Strobe and gap timer
    logic [23:0] poll_q, poll_d;  // Poll attempts
    logic [15:0] prev_q, prev_d;  // Last polled word
    logic polled_q, polled_d;     // A previous poll word exists
    bsfc_op_t op_q, op_d;
    logic ack_q, ack_d;
    // Three-stage pin synchronisers; stage one feeds stage two only
    logic [16:0] s1_q, s2_q, s3_q;
    logic [16:0] stab_q, stab_d;
    logic wb_req;
    bsfc_cyc_t cur;

    // Sequence table: cycle n of operation op
    function automatic bsfc_cyc_t seq_cycle(input bsfc_op_t op, input logic [2:0] n,
                                            input logic [20:0] a, input logic [15:0] d,
                                            input logic byp);
        bsfc_cyc_t c;
        c = '{addr: `BSFC_UNL_A1, data: `BSFC_UNL_D1, write: 1'b1};
        if (n == 3'd1) begin
            c.addr = `BSFC_UNL_A2;
            c.data = `BSFC_UNL_D2;
        end
        case (op)
            BSFC_OP_READ: c = '{addr: a, data: 16'h0000, write: 1'b0};
            // R8: bypass two-cycle program
            BSFC_OP_PROG: begin
                if (byp) begin
                    c = (n == 3'd0) ? '{addr: a, data: 16'h00A0, write: 1'b1}
                                    : '{addr: a, data: d, write: 1'b1};
                end else if (n == 3'd2) begin
                    c.data = 16'h00A0;
                end else if (n == 3'd3) begin
                    c = '{addr: a, data: d, write: 1'b1};
                end
            end
            // R9: erase one sector only
            BSFC_OP_SECT_ERASE: begin
                if (n == 3'd2) begin
                    c.data = 16'h0080;
                end else if (n == 3'd3) begin
                    c.data = `BSFC_UNL_D1;
                end else if (n == 3'd4) begin
                    c.addr = `BSFC_UNL_A2;
                    c.data = `BSFC_UNL_D2;
                end else if (n == 3'd5) begin
                    c = '{addr: a, data: 16'h0030, write: 1'b1};
                end
            end
            // R11: suspend pauses erase or program
            BSFC_OP_SUSPEND: c = '{addr: a, data: 16'h00B0, write: 1'b1};
            // R12: resume completes paused work
            BSFC_OP_RESUME: c = '{addr: a, data: 16'h0030, write: 1'b1};
            // R20: back to array read
            BSFC_OP_RESET_CMD: c = '{addr: a, data: 16'h00F0, write: 1'b1};
            // R16: region entry sequence
            BSFC_OP_REGION_ENTER: begin
                if (n == 3'd2) begin
                    c.data = 16'h0088;
                end
            end
            BSFC_OP_REGION_EXIT: begin
                if (n == 3'd2) begin
                    c.data = 16'h0090;
                end else if (n == 3'd3) begin
                    c = '{addr: a, data: 16'h0000, write: 1'b1};
                end
            end
            BSFC_OP_BYPASS_ENTER: begin
                if (n == 3'd2) begin
                    c.data = 16'h0020;
                end
            end
            BSFC_OP_BYPASS_EXIT: begin
                c = (n == 3'd0) ? '{addr: a, data: 16'h0090, write: 1'b1}
                                : '{addr: a, data: 16'h0000, write: 1'b1};
            end
            default: c = '{addr: a, data: 16'h0000, write: 1'b0};
        endcase
        return c;
    endfunction

    // Cycles per operation
    function automatic logic [2:0] seq_len(input bsfc_op_t op, input logic byp);
        case (op)
            BSFC_OP_PROG: seq_len = byp ? 3'd2 : 3'd4;
            BSFC_OP_SECT_ERASE: seq_len = 3'd6;
            BSFC_OP_REGION_ENTER: seq_len = 3'd3;
            BSFC_OP_REGION_EXIT: seq_len = 3'd4;
            BSFC_OP_BYPASS_ENTER: seq_len = 3'd3;
            BSFC_OP_BYPASS_EXIT: seq_len = 3'd2;
            default: seq_len = 3'd1;
        endcase
    endfunction

    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign cur = seq_cycle(op_q, idx_q, addr_q, wdat_q, bypass_q);

    // Synchroniser chain for dq and ready_busy_n
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 17'h1FFFF;
            s2_q <= 17'h1FFFF;
            s3_q <= 17'h1FFFF;
        end else begin
            s1_q <= {ready_busy_n_i, dq_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a pin change once stages two and three agree
    always_comb begin
        stab_d = stab_q;
        for (int i = 0; i < 17; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                stab_d[i] = s3_q[i];
            end
        end
    end

    // Next-state logic for bus slave and sequencer
    always_comb begin
        ctrl_d = ctrl_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        done_d = done_q;
        err_d = err_q;
        bypass_d = bypass_q;
        st_d = st_q;
        idx_d = idx_q;
        len_d = len_q;
        tmr_d = tmr_q;
        poll_d = poll_q;
        prev_d = prev_q;
        polled_d = polled_q;
        op_d = op_q;
        ack_d = wb_req;
        ctrl_d[`BSFC_CTRL_GO] = 1'b0;
        // Register writes; byte lane zero carries the go bit
        if (wb_req && wb_we_i) begin
            case (wb_adr_i)
                `BSFC_REG_CTRL: begin
                    if (wb_sel_i[0]) ctrl_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) ctrl_d[10:8] = wb_dat_i[10:8];
                end
                `BSFC_REG_ADDR: addr_d = wb_dat_i[20:0];
                `BSFC_REG_DATA: wdat_d = wb_dat_i[15:0];
                default: ;
            endcase
        end
        case (st_q)
            S_IDLE: begin
                // Orders while busy are ignored by design
                if (ctrl_d[`BSFC_CTRL_GO]) begin
                    op_d = bsfc_op_t'(ctrl_d[`BSFC_CTRL_CMD_MSB:`BSFC_CTRL_CMD_LSB]);
                    idx_d = 3'd0;
                    // Zero poll count marks a plain one-shot order
                    poll_d = 24'h000000;
                    len_d = seq_len(op_d, bypass_q);
                    done_d = 1'b0;
                    err_d = 1'b0;
                    polled_d = 1'b0;
                    st_d = S_SETUP;
                end
            end
            S_SETUP: begin
                tmr_d = 8'(`BSFC_STROBE_CYC);
                st_d = S_STROBE;
            end
            // R5: ordinary write or read cycle
            S_STROBE: begin
                if (tmr_q != 8'd0) begin
                    tmr_d = tmr_q - 8'd1;
                end else begin
                    if (!cur.write) rdat_d = stab_q[15:0];
                    tmr_d = 8'(`BSFC_STROBE_CYC);
                    st_d = S_GAP;
                end
            end
            // R14: deselect between cycles
            S_GAP: begin
                if (tmr_q != 8'd0) begin
                    tmr_d = tmr_q - 8'd1;
                end else if (idx_q + 3'd1 < len_q) begin
                    idx_d = idx_q + 3'd1;
                    st_d = S_SETUP;
                end else if (op_q == BSFC_OP_PROG || op_q == BSFC_OP_SECT_ERASE) begin
                    op_d = BSFC_OP_READ;
                    poll_d = 24'h000000;
                    st_d = S_SETUP;
                    idx_d = 3'd0;
                    len_d = 3'd1;
                    polled_d = 1'b0;
                    st_d = S_POLL;
                end else if (poll_q != 24'h000000) begin
                    // R6: status read done, judge it
                    st_d = S_POLL;
                end else begin
                    if (op_q == BSFC_OP_BYPASS_ENTER) bypass_d = 1'b1;
                    if (op_q == BSFC_OP_BYPASS_EXIT) bypass_d = 1'b0;
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
            // R6: toggle bit polling until steady
            S_POLL: begin
                if (polled_q && rdat_q[6] == prev_q[6]) begin
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end else if (polled_q && rdat_q[5] && (rdat_q[6] != prev_q[6])) begin
                    // R10: refused or failed operation
                    err_d = 1'b1;
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end else if (poll_q == `BSFC_POLL_MAX) begin
                    err_d = 1'b1;
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end else begin
                    prev_d = rdat_q;
                    polled_d = polled_q | (poll_q != 24'h000000);
                    poll_d = poll_q + 24'h000001;
                    st_d = S_SETUP;
                end
            end
            // R13: hold reset pin low
            S_HWRST: begin
                if (tmr_q != 8'd0) begin
                    tmr_d = tmr_q - 8'd1;
                end else begin
                    bypass_d = 1'b0;
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
        // R13: reset pulse preempts any running order
        if (ctrl_d[`BSFC_CTRL_HWRST] && st_q != S_HWRST) begin
            ctrl_d[`BSFC_CTRL_HWRST] = 1'b0;
            tmr_d = 8'(`BSFC_RST_CYC);
            st_d = S_HWRST;
        end
    end

    // Register stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `BSFC_CTRL_RST;
            addr_q <= 21'h000000;
            wdat_q <= 16'hFFFF;
            rdat_q <= 16'h0000;
            done_q <= 1'b0;
            err_q <= 1'b0;
            bypass_q <= 1'b0;
            st_q <= S_IDLE;
            idx_q <= 3'd0;
            len_q <= 3'd1;
            tmr_q <= 8'h00;
            poll_q <= 24'h000000;
            prev_q <= 16'h0000;
            polled_q <= 1'b0;
            op_q <= BSFC_OP_READ;
            ack_q <= 1'b0;
            stab_q <= 17'h1FFFF;
        end else begin
            ctrl_q <= ctrl_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            done_q <= done_d;
            err_q <= err_d;
            bypass_q <= bypass_d;
            st_q <= st_d;
            idx_q <= idx_d;
            len_q <= len_d;
            tmr_q <= tmr_d;
            poll_q <= poll_d;
            prev_q <= prev_d;
            polled_q <= polled_d;
            op_q <= op_d;
            ack_q <= ack_d;
            stab_q <= stab_d;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (wb_adr_i)
            `BSFC_REG_CTRL: wb_dat_o = {21'h000000, ctrl_q};
            `BSFC_REG_ADDR: wb_dat_o = {11'h000, addr_q};
            `BSFC_REG_DATA: wb_dat_o = {16'h0000, rdat_q};
            `BSFC_REG_STAT: wb_dat_o = {27'h0000000, bypass_q, stab_q[16], err_q, done_q,
                                        st_q != S_IDLE};
            default: wb_dat_o = 32'h00000000;
        endcase
    end
    assign wb_ack_o = ack_q;

    // R18: strobes from state; R15: lock pin from control
    always_comb begin
        pins_o.chip_select_n = !(st_q == S_STROBE);
        pins_o.write_strobe_n = !(st_q == S_STROBE && cur.write);
        pins_o.read_drive_n = !(st_q == S_STROBE && !cur.write);
        pins_o.reset_n = !(st_q == S_HWRST);
        pins_o.edge_sector_lock_n = ctrl_q[`BSFC_CTRL_WPN];
        pins_o.addr = cur.addr;
        pins_o.dq_out = cur.data;
        pins_o.dq_oe = (st_q == S_SETUP || st_q == S_STROBE || st_q == S_GAP) && cur.write;
    end
endmodule

// ---- bench/bsfc_ctrl_assertions.sv ----
/* Port checker for bsfc_ctrl.
 Assumes it is bound onto the controller and sees its ports only. */
`timescale 1ns/1ns
module bsfc_ctrl_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire bsfc_pkg::bsfc_pins_t pins_o,
    input wire logic [15:0] dq_i,
    input wire logic ready_busy_n_i
);
    import bsfc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_strobe_excl: assert property (!(!pins_o.write_strobe_n && !pins_o.read_drive_n))
        else $error("both strobes low");
    a_strobe_select: assert property (!pins_o.write_strobe_n || !pins_o.read_drive_n
        |-> !pins_o.chip_select_n) else $error("strobe without select");
    a_write_drives: assert property (!pins_o.write_strobe_n |-> pins_o.dq_oe)
        else $error("write without drive");
    a_read_floats: assert property (!pins_o.read_drive_n |-> !pins_o.dq_oe)
        else $error("drive during read");
    a_write_hold: assert property (!pins_o.write_strobe_n && $past(!pins_o.write_strobe_n)
        |-> $stable(pins_o.addr) && $stable(pins_o.dq_out)) else $error("write data moved");
    a_strobe_width: assert property ($fell(pins_o.write_strobe_n)
        |-> ##10 !pins_o.write_strobe_n ##1 pins_o.write_strobe_n) else $error("strobe width");
    a_select_release: assert property ($rose(pins_o.write_strobe_n)
        |-> ##[0:1] pins_o.chip_select_n) else $error("select held");
    a_idle_after_reset: assert property ($fell(rst_i) |-> pins_o.chip_select_n
        && pins_o.write_strobe_n && pins_o.read_drive_n && pins_o.reset_n && !pins_o.dq_oe
        && !wb_ack_o) else $error("pins busy after reset");
    a_reset_pulse: assert property ($fell(pins_o.reset_n) |-> (!pins_o.reset_n)[*8])
        else $error("reset pulse short");
endmodule
bind bsfc_ctrl bsfc_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o),
    .dq_i(dq_i), .ready_busy_n_i(ready_busy_n_i));

// ---- bench/bsfc_flash_model.sv ----
/* Behavioural boot-sector flash for the bench.
 Assumes bottom boot sectors; no suspend modelled, secured region shows serial words. */
`timescale 1ns/1ns
module bsfc_flash_model #(parameter int PROG_NS = 2000, parameter int ERASE_NS = 5000) (
    input wire bsfc_pkg::bsfc_pins_t pins_i,
    output logic [15:0] dq_o,
    output logic ready_busy_n_o
);
    import bsfc_pkg::*;
    logic [15:0] mem [int];
    int st = 0;
    int job = 0;
    int id;
    int q[$];
    logic byp = 0;
    logic sec = 0;  // Secured region mapped over the array
    logic busy = 0;
    logic tog = 0;
    logic kind;
    logic [7:0] c;
    logic [20:0] a;
    logic [20:0] ja;
    logic [15:0] jd;
    logic [15:0] rd = 16'hFFFF;
    function automatic int sect(logic [20:0] x);
        return (x < 21'h008000) ? int'(x[14:12]) : 8 + int'(x[20:15]);
    endfunction
    function automatic logic [15:0] word(logic [20:0] x);
        return mem.exists(int'(x)) ? mem[int'(x)] : 16'hFFFF;
    endfunction
    task automatic launch(input logic k, input logic [20:0] x, input logic [15:0] d);
        if (pins_i.edge_sector_lock_n || x >= 21'h002000) begin
            kind = k; ja = x; jd = d; job++; busy = 1;
        end
    endtask
    always @(negedge pins_i.write_strobe_n) begin
        if (!pins_i.chip_select_n && pins_i.reset_n && !busy) begin
            c = pins_i.dq_out[7:0];
            a = pins_i.addr;
            // Program data that looks like a reset code is still data
            if (c == 8'hF0 && st != 6) st = 0;
            else case (st)
                0: st = (byp && c == 8'hA0) ? 6 : (byp && c == 8'h90) ? 7
                    : (c == 8'hAA && a == 21'h000555) ? 1 : 0;
                1: st = (c == 8'h55 && a == 21'h0002AA) ? 2 : 0;
                2: begin
                    st = (c == 8'hA0) ? 6 : (c == 8'h80) ? 3 : (c == 8'h90) ? 7 : 0;
                    if (c == 8'h20) byp = 1;
                    if (c == 8'h88) sec = 1;
                end
                3: st = (c == 8'hAA) ? 4 : 0;
                4: st = (c == 8'h55) ? 5 : 0;
                5: begin
                    st = 0;
                    if (c == 8'h30) launch(1, a, 16'hFFFF);
                end
                6: begin
                    st = 0;
                    launch(0, a, pins_i.dq_out);
                end
                default: begin
                    st = 0;
                    if (c == 8'h00) begin
                        byp = 0;
                        sec = 0;
                    end
                end
            endcase
        end
    end
    // Finish job: one sector, or clear bits only
    always @(posedge busy) begin
        id = job;
        #(kind ? ERASE_NS : PROG_NS);
        if (id == job && busy) begin
            q = {};
            if (kind) foreach (mem[k]) if (sect(21'(k)) == sect(ja)) q.push_back(k);
            foreach (q[i]) mem.delete(q[i]);
            if (!kind) mem[int'(ja)] = word(ja) & jd;
            busy = 0;
        end
    end
    // Status toggles while busy; region shows serial words
    always @(negedge pins_i.read_drive_n) begin
        if (!pins_i.chip_select_n && pins_i.reset_n) begin
            tog = !tog;
            rd = busy ? {8'h00, ~jd[7], tog, 6'h00}
                : sec ? (16'h5EC0 | {13'h0000, pins_i.addr[2:0]}) : word(pins_i.addr);
        end
    end
    // Reset pin aborts, back to read
    always @(negedge pins_i.reset_n) begin
        busy = 0; st = 0; byp = 0; sec = 0; job++;
    end
    // Released bus shows the inverse, not stale data
    assign dq_o = (!pins_i.chip_select_n && !pins_i.read_drive_n && pins_i.reset_n) ? rd : ~rd;
    assign ready_busy_n_o = !busy;
endmodule

// ---- bench/bsfc_ctrl_tb_top.sv ----
/* Self-checking bench for bsfc_ctrl over Wishbone.
 Assumes the flash model on the far side and the params header. */
`timescale 1ns/1ns
`include "bsfc_params.svh"
module bsfc_ctrl_tb_top;
    import bsfc_pkg::*;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, ryby;
    logic [3:0] wb_adr, wb_sel;
    logic [31:0] wb_dat, wb_q, q, seed, d1, d2, d3;
    logic [20:0] a1, a2;
    logic [15:0] dq;
    bsfc_pins_t pins;
    int n_fail = 0;
    int total_checks = 0;
    int nw = 0;
    int cycles = 0;
    bsfc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .pins_o(pins), .dq_i(dq), .ready_busy_n_i(ryby));
    bsfc_flash_model u_flash (.pins_i(pins), .dq_o(dq), .ready_busy_n_o(ryby));
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    // Count flash write cycles per operation
    always @(negedge pins.write_strobe_n) nw++;
    // Hang guard, well above the run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            report_and_stop;
        end
    end
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1; wb_stb <= 1; wb_we <= w; wb_adr <= a; wb_dat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        q = wb_q;
        wb_cyc <= 0; wb_stb <= 0;
    endtask
    task automatic go(input bsfc_op_t c, input logic [20:0] a, input logic [31:0] d,
        input logic lk);
        wb(1, `BSFC_REG_ADDR, {11'h000, a});
        wb(1, `BSFC_REG_DATA, d);
        nw = 0;
        wb(1, `BSFC_REG_CTRL, {21'h0, lk, 2'h0, c, 4'h1});
    endtask
    task automatic op(input bsfc_op_t c, input logic [20:0] a, input logic [31:0] d,
        input logic lk);
        go(c, a, d, lk);
        do wb(0, `BSFC_REG_STAT, 0); while (q[1] !== 1'b1);
    endtask
    task automatic rd_word(input logic [20:0] a);
        op(BSFC_OP_READ, a, 0, 1);
        wb(0, `BSFC_REG_DATA, 0);
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        rst_i = 1; wb_cyc = 0; wb_stb = 0; wb_we = 0; wb_adr = 0; wb_sel = 4'hF; wb_dat = 0;
        seed = 32'hC1B6648B;
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        // Reset value, then an unmapped place
        wb(0, `BSFC_REG_CTRL, 0); chk(q, 32'h400);
        wb(1, 4'h1, 32'hFFFFFFFF); wb(0, 4'h1, 0); chk(q, 32'h0);
        wb(0, `BSFC_REG_CTRL, 0); chk(q, 32'h400);
        // Random words in two disjoint halves
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed); a1 = {1'b1, i[0], seed[18:0]}; a2 = a1 ^ 21'h008000;
            seed = lfsr(seed); d1 = {16'h0, seed[15:0]}; d2 = {16'h0, seed[31:16]};
            seed = lfsr(seed); d3 = {16'h0, seed[15:0]};
            rd_word(a1); chk(q, 32'hFFFF);
            op(BSFC_OP_PROG, a1, d1, 1); chk(nw, 4);
            rd_word(a1); chk(q, d1);
            op(BSFC_OP_PROG, a1, d2, 1); rd_word(a1); chk(q, d1 & d2);
            op(BSFC_OP_PROG, a2, d3, 1);
            op(BSFC_OP_SECT_ERASE, a1, 0, 1); rd_word(a1); chk(q, 32'hFFFF);
            rd_word(a2); chk(q, d3);
        end
        // Two-cycle program in bypass
        op(BSFC_OP_BYPASS_ENTER, 0, 0, 1);
        wb(0, `BSFC_REG_STAT, 0); chk(q[4], 1);
        op(BSFC_OP_PROG, a1, d1, 1); chk(nw, 2);
        op(BSFC_OP_BYPASS_EXIT, 0, 0, 1); rd_word(a1); chk(q, d1);
        // Reset command, suspend and resume with nothing running
        op(BSFC_OP_RESET_CMD, a1, 0, 1); chk(nw, 1);
        op(BSFC_OP_SUSPEND, a1, 0, 1); chk(nw, 1);
        op(BSFC_OP_RESUME, a1, 0, 1); chk(nw, 1);
        // Secured region shows serial words until exit
        op(BSFC_OP_REGION_ENTER, 0, 0, 1); chk(nw, 3);
        rd_word(21'h000003); chk(q, 32'h5EC3);
        op(BSFC_OP_REGION_EXIT, 0, 0, 1); chk(nw, 4);
        rd_word(a1); chk(q, d1);
        // Edge sector locked, then unlocked
        op(BSFC_OP_PROG, 21'h000100, 0, 0); rd_word(21'h000100); chk(q, 32'hFFFF);
        op(BSFC_OP_PROG, 21'h000100, d2, 1); rd_word(21'h000100); chk(q, d2);
        // Reset pin in mid erase
        go(BSFC_OP_SECT_ERASE, a2, 0, 1);
        repeat (250) @(posedge clk_i);
        wb(1, `BSFC_REG_CTRL, 32'h600);
        do wb(0, `BSFC_REG_STAT, 0); while (q[0] !== 1'b0);
        repeat (80) @(posedge clk_i);
        rd_word(a2); chk(q, d3);
        wb(0, `BSFC_REG_STAT, 0); chk(q[3], 1);
        report_and_stop;
    end
endmodule
